//--- logic/hdbf_pkg.sv
package hdbf_pkg;

	// Frame layout
	localparam logic [8:0] HDBF_PROLOGUE_LEN = 9'h003;
	localparam logic [7:0] HDBF_LEN_MAX = 8'hfe;
	localparam logic [7:0] HDBF_LEN_RESERVED = 8'hff;
	localparam logic [7:0] HDBF_NAD_INVALID = 8'hff;
	localparam logic [7:0] HDBF_NAD_DEPRECATED_MASK = 8'h77;
	localparam int HDBF_NAD_SAD_LSB = 0;
	localparam int HDBF_NAD_DAD_LSB = 4;

	// Control byte codes
	localparam logic [1:0] HDBF_PCB_R = 2'h2;
	localparam logic [1:0] HDBF_PCB_S = 2'h3;
	localparam logic [3:0] HDBF_R_CODE_MAX = 4'h2;
	localparam logic [5:0] HDBF_S_RESYNCH = 6'h00;
	localparam logic [5:0] HDBF_S_IFS = 6'h01;
	localparam logic [5:0] HDBF_S_ABORT = 6'h02;
	localparam logic [5:0] HDBF_S_WTX = 6'h03;
	localparam logic [5:0] HDBF_S_RESP = 6'h20;
	localparam logic [7:0] HDBF_PCB_IFS_REQ = 8'hc1;

	// Protocol parameters and defaults
	localparam logic [7:0] HDBF_IFS_DEFAULT = 8'h20;
	localparam logic [3:0] HDBF_CWI_DEFAULT = 4'hd;
	localparam logic [3:0] HDBF_BWI_DEFAULT = 4'h4;
	localparam logic [3:0] HDBF_BWI_MAX = 4'h9;
	localparam logic [7:0] HDBF_N_MIN_GUARD = 8'hff;

	// Timing, in etu or in Fd/f units
	localparam logic [15:0] HDBF_CWT_BASE_ETU = 16'h000b;
	localparam logic [3:0] HDBF_BWT_BASE_ETU = 4'hb;
	localparam logic [18:0] HDBF_BWT_UNIT = 19'h003c0;
	localparam logic [15:0] HDBF_BGT_ETU = 16'h0016;
	localparam logic [8:0] HDBF_GT_BASE_ETU = 9'h00c;
	localparam logic [8:0] HDBF_CGT_MIN_ETU = 9'h00b;

	// Two-byte check code engine
	localparam logic [15:0] HDBF_CRC_POLY = 16'h1021;
	localparam logic [15:0] HDBF_CRC_INIT = 16'hffff;

	typedef enum logic [1:0] {HDBF_M_IDLE, HDBF_M_RECV, HDBF_M_OWN, HDBF_M_SEND} hdbf_mode_t;

	typedef enum logic [2:0] {
		HDBF_E_NONE, HDBF_E_PARITY, HDBF_E_CODE, HDBF_E_PCB, HDBF_E_LEN, HDBF_E_NAD, HDBF_E_SYNC
	} hdbf_err_t;

	typedef struct packed {
		logic [7:0] nad;
		logic [7:0] pcb;
		logic [7:0] len;
	} hdbf_hdr_t;

	typedef struct packed {
		logic [7:0] ta;
		logic [7:0] tb;
		logic [7:0] tc;
		logic [7:0] n;
		logic taPresent;
		logic tbPresent;
		logic tcPresent;
	} hdbf_cfg_t;

	typedef struct packed {
		hdbf_mode_t mode;
		logic drain;
		logic [8:0] idx;
		hdbf_hdr_t rxHdr;
		hdbf_hdr_t txHdr;
		logic [7:0] lrc;
		hdbf_err_t err;
		logic [15:0] sinceTx;
		logic [15:0] sinceRx;
		logic bwtRun;
		logic [3:0] bwtEtu;
		logic [18:0] bwtFd;
		logic bwtExpired;
		logic [7:0] ifsc;
		logic [7:0] ifsd;
		logic crcMode;
		logic [3:0] cwi;
		logic [3:0] bwi;
		logic [8:0] cgt;
		logic [7:0] rxInfLast;
		logic [7:0] txInfLast;
		logic [7:0] txByte;
		logic txStrobe;
		logic txDone;
		logic txReject;
		logic txInfReady;
		logic rxHdrValid;
		logic [7:0] rxInfData;
		logic rxInfValid;
		logic rxDone;
		hdbf_err_t rxErr;
		logic cfgReserved;
		logic strayChar;
		logic charRepeat;
	} hdbf_state_t;

endpackage

//--- logic/hdbf_crc16.sv
`timescale 1ns/100ps
module hdbf_crc16 #(
	parameter logic [15:0] POLY = hdbf_pkg::HDBF_CRC_POLY,
	parameter logic [15:0] INIT = hdbf_pkg::HDBF_CRC_INIT
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Byte stream
	input wire logic clear,
	input wire logic enable,
	input wire logic [7:0] data,
	// Result
	output logic [15:0] crc
);

	logic [15:0] next_crc;

	// Most significant bit first, one byte per enabled cycle
	always_comb
	begin
		logic [15:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--)
		begin
			if (c[15] ^ data[i])
				c = {c[14:0], 1'b0} ^ POLY;
			else
				c = {c[14:0], 1'b0};
		end
		if (clear)
			next_crc = INIT;
		else if (enable)
			next_crc = c;
		else
			next_crc = crc;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			crc <= INIT;
		else
			crc <= next_crc;
	end

endmodule

//--- logic/hdbf_framer.sv
`timescale 1ns/100ps
// Functional notes
// - Block is NAD, PCB, LEN, 0..254 info bytes, then 1 or 2 check bytes.
// - NAD FF never sent and rejected on receive.
// - NAD bits 1-3 source address, bits 5-7 destination address.
// - NAD bits 4 and 8 sent as zero, ignored on receive.
// - Equal nonzero source and destination addresses are reserved and refused.
// - R-block PCB 10, bit 5 N(R), low nibble 0, 1 or 2.
// - Received R-block low nibble may be ignored.
// - S-block PCB 11 with resynch, IFS, abort, WTX codes; bit 6 response.
// - LEN 00 none, 01-FE length, FF invalid.
// - R has no info; IFS and WTX one byte; abort and resynch none.
// - LRC byte makes XOR of whole block zero; else rejected.
// - TC bit 1 selects CRC, otherwise LRC; TC bits 8-2 must be zero.
// - IFSC from TA else 32; IFSD starts at 32.
// - IFS values 01-FE valid; 00 and FF reserved.
// - CWT is 11 plus 2^CWI etu; CWI from TB bits 4-1, default 13.
// - Character spacing within block bounded by CWT; the receiver times out after the larger of CWT and 22 etu; expiry ends bad block.
// - BWT is 11 etu plus 2^BWI*960 Fd/f; BWI default 4, valid 0-9.
// - Interface device holds transmit right at start; all characters belong to blocks.
// - Sender enters reception; receiver of full block takes transmit right.
// - Opposite direction leading edges at least 22 etu apart.
// - Same direction characters spaced at least CGT, 11 etu when N is 255.
// - No error signal and no character repetition.
module hdbf_framer (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Timing ticks and activation
	input wire logic etuTick,
	input wire logic fdTick,
	input wire logic protoStart,
	input wire hdbf_pkg::hdbf_cfg_t cfg,
	// Character receiver
	input wire logic rxStart,
	input wire logic rxValid,
	input wire logic [7:0] rxByte,
	input wire logic rxParityErr,
	// Character transmitter
	output logic [7:0] txByte,
	output logic txStrobe,
	output logic charRepeat,
	// Block layer transmit side
	input wire logic txReq,
	input wire hdbf_pkg::hdbf_hdr_t txHdr,
	input wire logic [7:0] txInfData,
	input wire logic txInfValid,
	output logic txInfReady,
	output logic txDone,
	output logic txReject,
	// Block layer receive side
	output hdbf_pkg::hdbf_hdr_t rxHdr,
	output logic rxHdrValid,
	output logic [7:0] rxInfData,
	output logic rxInfValid,
	output logic rxDone,
	output hdbf_pkg::hdbf_err_t rxErr,
	output logic strayChar,
	// Status
	output logic haveRight,
	output logic bwtExpired,
	output logic cfgReserved,
	output logic [7:0] ifsc,
	output logic [7:0] ifsd
);

	hdbf_pkg::hdbf_state_t s;
	hdbf_pkg::hdbf_state_t next_s;
	logic crcClear;
	logic crcEnable;
	logic [7:0] crcData;
	logic [15:0] crcValue;

	hdbf_crc16 #(
		.POLY(hdbf_pkg::HDBF_CRC_POLY),
		.INIT(hdbf_pkg::HDBF_CRC_INIT)
	) u_crc (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clear(crcClear),
		.enable(crcEnable),
		.data(crcData),
		.crc(crcValue)
	);

	// Header legality, shared by both directions; limit is IFSC on receive, IFSD on transmit
	function automatic hdbf_pkg::hdbf_err_t checkHdr(input hdbf_pkg::hdbf_hdr_t h,
		input logic [7:0] limit, input logic strictR);
		logic [2:0] sad;
		logic [2:0] dad;
		hdbf_pkg::hdbf_err_t e;
		sad = h.nad[hdbf_pkg::HDBF_NAD_SAD_LSB +: 3];
		dad = h.nad[hdbf_pkg::HDBF_NAD_DAD_LSB +: 3];
		e = hdbf_pkg::HDBF_E_NONE;
		if (h.nad == hdbf_pkg::HDBF_NAD_INVALID)
			e = hdbf_pkg::HDBF_E_NAD;
		else if (sad == dad && sad != 3'h0)
			e = hdbf_pkg::HDBF_E_NAD;
		else if (h.len == hdbf_pkg::HDBF_LEN_RESERVED)
			e = hdbf_pkg::HDBF_E_LEN;
		else
		begin
			case (h.pcb[7:6])
				hdbf_pkg::HDBF_PCB_R:
				begin
					if (h.pcb[5] || (strictR && h.pcb[3:0] > hdbf_pkg::HDBF_R_CODE_MAX))
						e = hdbf_pkg::HDBF_E_PCB;
					else if (h.len != 8'h00)
						e = hdbf_pkg::HDBF_E_LEN;
				end
				hdbf_pkg::HDBF_PCB_S:
				begin
					case (h.pcb[5:0] & ~hdbf_pkg::HDBF_S_RESP)
						hdbf_pkg::HDBF_S_RESYNCH, hdbf_pkg::HDBF_S_ABORT:
							if (h.len != 8'h00)
								e = hdbf_pkg::HDBF_E_LEN;
						hdbf_pkg::HDBF_S_IFS, hdbf_pkg::HDBF_S_WTX:
							if (h.len != 8'h01)
								e = hdbf_pkg::HDBF_E_LEN;
						default:
							e = hdbf_pkg::HDBF_E_PCB;
					endcase
				end
				default:
				begin
					if (h.pcb[4:0] != 5'h00)
						e = hdbf_pkg::HDBF_E_PCB;
					else if (h.len > limit)
						e = hdbf_pkg::HDBF_E_LEN;
				end
			endcase
		end
		return e;
	endfunction

	always_comb
	begin
		logic [8:0] epiLen;
		logic [8:0] infEnd;
		logic [8:0] lastIdx;
		logic [15:0] cwt;
		logic [15:0] silence;
		logic [7:0] lrcNew;
		logic gapOk;
		logic haveByte;
		logic [7:0] outByte;
		logic finish;
		hdbf_pkg::hdbf_hdr_t h;
		hdbf_pkg::hdbf_err_t e;
		next_s = s;
		crcClear = 1'b0;
		crcEnable = 1'b0;
		crcData = 8'h00;
		finish = 1'b0;
		gapOk = 1'b0;
		haveByte = 1'b0;
		outByte = 8'h00;
		h = s.rxHdr;
		e = hdbf_pkg::HDBF_E_NONE;
		lrcNew = s.lrc ^ rxByte;
		epiLen = s.crcMode ? 9'h002 : 9'h001;
		cwt = hdbf_pkg::HDBF_CWT_BASE_ETU + (16'h0001 << s.cwi);
		silence = (cwt > hdbf_pkg::HDBF_BGT_ETU) ? cwt : hdbf_pkg::HDBF_BGT_ETU;
		next_s.txStrobe = 1'b0;
		next_s.txDone = 1'b0;
		next_s.txReject = 1'b0;
		next_s.txInfReady = 1'b0;
		next_s.rxHdrValid = 1'b0;
		next_s.rxInfValid = 1'b0;
		next_s.rxDone = 1'b0;
		next_s.strayChar = 1'b0;
		next_s.charRepeat = 1'b0;

		// Leading-edge timers in etu, saturating
		if (etuTick && s.sinceTx != 16'hffff)
			next_s.sinceTx = s.sinceTx + 16'h0001;
		if (etuTick && s.sinceRx != 16'hffff)
			next_s.sinceRx = s.sinceRx + 16'h0001;
		if (rxStart)
		begin
			next_s.sinceRx = 16'h0000;
			next_s.bwtRun = 1'b0;
		end

		// Waiting time: fixed etu part, then 2^BWI*960 Fd/f units
		if (s.bwtRun && !s.bwtExpired)
		begin
			if (s.bwtEtu != hdbf_pkg::HDBF_BWT_BASE_ETU)
			begin
				if (etuTick)
					next_s.bwtEtu = s.bwtEtu + 4'h1;
			end
			else if (s.bwtFd == (hdbf_pkg::HDBF_BWT_UNIT << s.bwi))
				next_s.bwtExpired = 1'b1;
			else if (fdTick)
				next_s.bwtFd = s.bwtFd + 19'h00001;
		end

		case (s.mode)
			hdbf_pkg::HDBF_M_RECV:
			begin
				infEnd = hdbf_pkg::HDBF_PROLOGUE_LEN + {1'b0, s.rxHdr.len};
				lastIdx = infEnd + epiLen - 9'h001;
				if (rxValid)
				begin
					crcData = rxByte;
					crcEnable = (s.idx < hdbf_pkg::HDBF_PROLOGUE_LEN) || (s.idx < infEnd);
					next_s.lrc = lrcNew;
					next_s.idx = s.idx + 9'h001;
					if (rxParityErr && s.err == hdbf_pkg::HDBF_E_NONE)
						next_s.err = hdbf_pkg::HDBF_E_PARITY;
					if (s.idx == 9'h000)
						next_s.rxHdr.nad = rxByte;
					else if (s.idx == 9'h001)
						next_s.rxHdr.pcb = rxByte;
					else if (s.idx == 9'h002)
					begin
						h.len = rxByte;
						next_s.rxHdr.len = rxByte;
						next_s.rxHdrValid = 1'b1;
						e = checkHdr(h, s.ifsc, 1'b0);
						if (e != hdbf_pkg::HDBF_E_NONE)
						begin
							next_s.drain = 1'b1;
							if (s.err == hdbf_pkg::HDBF_E_NONE)
								next_s.err = e;
						end
					end
					else if (!s.drain)
					begin
						if (s.idx < infEnd)
						begin
							next_s.rxInfData = rxByte;
							next_s.rxInfValid = 1'b1;
							next_s.rxInfLast = rxByte;
						end
						else if (s.crcMode)
						begin
							if (s.idx == infEnd && rxByte != crcValue[15:8] ||
								s.idx != infEnd && rxByte != crcValue[7:0])
								if (s.err == hdbf_pkg::HDBF_E_NONE && next_s.err == s.err)
									next_s.err = hdbf_pkg::HDBF_E_CODE;
						end
						else if (lrcNew != 8'h00 && s.err == hdbf_pkg::HDBF_E_NONE &&
							next_s.err == s.err)
							next_s.err = hdbf_pkg::HDBF_E_CODE;
						if (s.idx == lastIdx)
							finish = 1'b1;
					end
				end
				else if (s.idx != 9'h000 && s.sinceRx > silence)
				begin
					finish = 1'b1;
					if (!s.drain && s.err == hdbf_pkg::HDBF_E_NONE)
						next_s.err = hdbf_pkg::HDBF_E_SYNC;
				end
				if (finish)
				begin
					next_s.mode = hdbf_pkg::HDBF_M_OWN;
					next_s.rxDone = 1'b1;
					next_s.rxErr = next_s.err;
					next_s.idx = 9'h000;
					next_s.drain = 1'b0;
					if (next_s.err == hdbf_pkg::HDBF_E_NONE &&
						s.rxHdr.pcb == hdbf_pkg::HDBF_PCB_IFS_REQ &&
						next_s.rxInfLast != 8'h00 && next_s.rxInfLast != 8'hff)
						next_s.ifsd = next_s.rxInfLast;
				end
			end
			hdbf_pkg::HDBF_M_OWN:
			begin
				if (rxValid)
					next_s.strayChar = 1'b1;
				if (txReq)
				begin
					h = txHdr;
					h.nad = txHdr.nad & hdbf_pkg::HDBF_NAD_DEPRECATED_MASK;
					e = checkHdr(h, s.ifsd, 1'b1);
					if (e == hdbf_pkg::HDBF_E_NONE)
					begin
						next_s.txHdr = h;
						next_s.mode = hdbf_pkg::HDBF_M_SEND;
						next_s.idx = 9'h000;
						next_s.lrc = 8'h00;
						crcClear = 1'b1;
					end
					else
						next_s.txReject = 1'b1;
				end
			end
			hdbf_pkg::HDBF_M_SEND:
			begin
				if (rxValid)
					next_s.strayChar = 1'b1;
				infEnd = hdbf_pkg::HDBF_PROLOGUE_LEN + {1'b0, s.txHdr.len};
				lastIdx = infEnd + epiLen - 9'h001;
				if (s.idx == 9'h000)
					gapOk = s.sinceRx >= hdbf_pkg::HDBF_BGT_ETU;
				else
					gapOk = {7'h00, s.sinceTx[8:0]} >= {7'h00, s.cgt} ||
						s.sinceTx[15:9] != 7'h00;
				haveByte = 1'b1;
				if (s.idx == 9'h000)
					outByte = s.txHdr.nad;
				else if (s.idx == 9'h001)
					outByte = s.txHdr.pcb;
				else if (s.idx == 9'h002)
					outByte = s.txHdr.len;
				else if (s.idx < infEnd)
				begin
					haveByte = txInfValid;
					outByte = txInfData;
				end
				else if (!s.crcMode)
					outByte = s.lrc;
				else if (s.idx == infEnd)
					outByte = crcValue[15:8];
				else
					outByte = crcValue[7:0];
				if (gapOk && haveByte && !s.txStrobe)
				begin
					next_s.txByte = outByte;
					next_s.txStrobe = 1'b1;
					next_s.sinceTx = 16'h0000;
					next_s.lrc = s.lrc ^ outByte;
					next_s.idx = s.idx + 9'h001;
					crcData = outByte;
					crcEnable = s.idx < infEnd;
					if (s.idx >= hdbf_pkg::HDBF_PROLOGUE_LEN && s.idx < infEnd)
					begin
						next_s.txInfReady = 1'b1;
						next_s.txInfLast = outByte;
					end
					if (s.idx == lastIdx)
					begin
						next_s.mode = hdbf_pkg::HDBF_M_RECV;
						next_s.txDone = 1'b1;
						next_s.idx = 9'h000;
						next_s.lrc = 8'h00;
						next_s.err = hdbf_pkg::HDBF_E_NONE;
						next_s.bwtRun = 1'b1;
						next_s.bwtEtu = 4'h0;
						next_s.bwtFd = 19'h00000;
						next_s.bwtExpired = 1'b0;
						crcClear = 1'b1;
						if (s.txHdr.pcb == hdbf_pkg::HDBF_PCB_IFS_REQ &&
							next_s.txInfLast != 8'h00 && next_s.txInfLast != 8'hff)
							next_s.ifsc = next_s.txInfLast;
					end
				end
			end
			default:
				next_s.mode = hdbf_pkg::HDBF_M_IDLE;
		endcase

		if (s.mode == hdbf_pkg::HDBF_M_RECV && s.idx == 9'h000 && rxValid)
			next_s.err = rxParityErr ? hdbf_pkg::HDBF_E_PARITY : hdbf_pkg::HDBF_E_NONE;

		// Activation: the other end holds the right, card listens first
		if (protoStart)
		begin
			next_s.mode = hdbf_pkg::HDBF_M_RECV;
			next_s.idx = 9'h000;
			next_s.drain = 1'b0;
			next_s.lrc = 8'h00;
			next_s.err = hdbf_pkg::HDBF_E_NONE;
			next_s.bwtRun = 1'b0;
			next_s.bwtExpired = 1'b0;
			crcClear = 1'b1;
			next_s.ifsd = hdbf_pkg::HDBF_IFS_DEFAULT;
			next_s.ifsc = (cfg.taPresent && cfg.ta != 8'h00 && cfg.ta != 8'hff) ?
				cfg.ta : hdbf_pkg::HDBF_IFS_DEFAULT;
			next_s.cwi = cfg.tbPresent ? cfg.tb[3:0] : hdbf_pkg::HDBF_CWI_DEFAULT;
			next_s.bwi = (cfg.tbPresent && cfg.tb[7:4] <= hdbf_pkg::HDBF_BWI_MAX) ?
				cfg.tb[7:4] : hdbf_pkg::HDBF_BWI_DEFAULT;
			next_s.crcMode = cfg.tcPresent && cfg.tc[0];
			next_s.cgt = (cfg.n == hdbf_pkg::HDBF_N_MIN_GUARD) ? hdbf_pkg::HDBF_CGT_MIN_ETU :
				hdbf_pkg::HDBF_GT_BASE_ETU + {1'b0, cfg.n};
			next_s.cfgReserved = (cfg.tcPresent && cfg.tc[7:1] != 7'h00) ||
				(cfg.tbPresent && cfg.tb[7:4] > hdbf_pkg::HDBF_BWI_MAX) ||
				(cfg.taPresent && (cfg.ta == 8'h00 || cfg.ta == 8'hff));
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.mode <= hdbf_pkg::HDBF_M_IDLE;
			s.err <= hdbf_pkg::HDBF_E_NONE;
			s.rxErr <= hdbf_pkg::HDBF_E_NONE;
			s.sinceTx <= 16'hffff;
			s.sinceRx <= 16'hffff;
			s.ifsc <= hdbf_pkg::HDBF_IFS_DEFAULT;
			s.ifsd <= hdbf_pkg::HDBF_IFS_DEFAULT;
			s.cwi <= hdbf_pkg::HDBF_CWI_DEFAULT;
			s.bwi <= hdbf_pkg::HDBF_BWI_DEFAULT;
			s.cgt <= hdbf_pkg::HDBF_GT_BASE_ETU;
		end
		else
			s <= next_s;
	end

	assign txByte = s.txByte;
	assign txStrobe = s.txStrobe;
	assign charRepeat = s.charRepeat;
	assign txInfReady = s.txInfReady;
	assign txDone = s.txDone;
	assign txReject = s.txReject;
	assign rxHdr = s.rxHdr;
	assign rxHdrValid = s.rxHdrValid;
	assign rxInfData = s.rxInfData;
	assign rxInfValid = s.rxInfValid;
	assign rxDone = s.rxDone;
	assign rxErr = s.rxErr;
	assign strayChar = s.strayChar;
	assign haveRight = (s.mode == hdbf_pkg::HDBF_M_OWN);
	assign bwtExpired = s.bwtExpired;
	assign cfgReserved = s.cfgReserved;
	assign ifsc = s.ifsc;
	assign ifsd = s.ifsd;

endmodule

//--- dv/hdbf_framer_asserts.sv
`timescale 1ns/100ps
module hdbf_framer_asserts (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Timing and config
	input wire logic etuTick,
	input wire logic rxStart,
	input wire hdbf_pkg::hdbf_cfg_t cfg,
	// Transmit side
	input wire logic [7:0] txByte,
	input wire logic txStrobe,
	input wire logic charRepeat,
	input wire logic txInfReady,
	input wire logic txDone,
	input wire logic txReject,
	// Receive side and status
	input wire logic rxDone,
	input wire hdbf_pkg::hdbf_err_t rxErr,
	input wire logic haveRight,
	input wire logic [7:0] ifsc,
	input wire logic [7:0] ifsd
);
	logic [5:0] sinceRx;
	logic [8:0] sinceTx;
	logic [8:0] idx;
	logic [7:0] acc;
	logic [8:0] cgt;
	// Guard count fixed for the run, so live value equals the loaded one
	assign cgt = (cfg.n == 8'hff) ? 9'h00b : 9'h00c + {1'h0, cfg.n};
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			sinceRx <= 6'h3f;
		else if (rxStart)
			sinceRx <= 6'h00;
		else if (etuTick && sinceRx != 6'h3f)
			sinceRx <= sinceRx + 6'h01;
		if (!rst_n)
			sinceTx <= 9'h1ff;
		else if (txStrobe)
			sinceTx <= 9'h000;
		else if (etuTick && sinceTx != 9'h1ff)
			sinceTx <= sinceTx + 9'h001;
		if (!rst_n || haveRight)
		begin
			idx <= 9'h000;
			acc <= 8'h00;
		end
		else if (txStrobe)
		begin
			idx <= idx + 9'h001;
			acc <= acc ^ txByte;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	no_repeat_a: assert property (charRepeat == 1'b0)
		else $error("character repetition raised");
	block_gap_a: assert property (txStrobe |-> sinceRx >= 6'h16)
		else $error("turnaround gap too short");
	char_gap_a: assert property (txStrobe && idx != 9'h000 |-> sinceTx >= cgt)
		else $error("character gap too short");
	nad_bits_a: assert property (txStrobe && idx == 9'h000 |-> txByte[7] == 1'b0 &&
		txByte[3] == 1'b0) else $error("bad address byte sent");
	nad_pair_a: assert property (txStrobe && idx == 9'h000 |-> txByte[2:0] == 3'h0 ||
		txByte[6:4] != txByte[2:0]) else $error("reserved address pair sent");
	lrc_zero_a: assert property (txDone && !cfg.tc[0] |-> (acc ^ txByte) == 8'h00)
		else $error("block check byte wrong");
	inf_slot_a: assert property (txInfReady |-> txStrobe && idx >= 9'h003)
		else $error("info byte outside its field");
	send_recv_a: assert property (txDone |=> !haveRight [*2])
		else $error("right kept after sending");
	recv_right_a: assert property (rxDone && rxErr == hdbf_pkg::HDBF_E_NONE |-> ##[0:1] haveRight)
		else $error("right not taken after block");
	reject_hold_a: assert property (txReject |-> haveRight && !txStrobe)
		else $error("rejected block started");
	size_reset_a: assert property ($rose(rst_n) |-> ifsc == 8'h20 && ifsd == 8'h20)
		else $error("information sizes not at default");
endmodule

//--- dv/hdbf_ifd_model.sv
`timescale 1ns/100ps
module hdbf_ifd_model (
	// Clock
	input wire logic ref_clk,
	// Ticks
	output logic etuTick,
	output logic fdTick,
	// Characters toward the card
	output logic rxStart,
	output logic rxValid,
	output logic [7:0] rxByte,
	output logic rxParityErr
);
	logic [1:0] div = 2'h0;
	initial
	begin
		etuTick = 1'b0;
		fdTick = 1'b0;
		rxStart = 1'b0;
		rxValid = 1'b0;
		rxByte = 8'h00;
		rxParityErr = 1'b0;
	end
	always @(posedge ref_clk)
	begin
		div <= div + 2'h1;
		etuTick <= (div == 2'h3);
		fdTick <= div[0];
	end
	// Two-byte check code over a byte string, most significant bit first
	function automatic logic [15:0] crcOf(input logic [7:0] b[$]);
		logic [15:0] c;
		c = hdbf_pkg::HDBF_CRC_INIT;
		foreach (b[i])
			for (int k = 7; k >= 0; k--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][k]) ? hdbf_pkg::HDBF_CRC_POLY : 16'h0000);
		return c;
	endfunction
	task automatic waitEtu(input int n);
		repeat (n) @(posedge ref_clk iff etuTick);
	endtask
	// Leading edges 12 etu apart: above CGT of 11, below CWT of 13
	task automatic sendChar(input logic [7:0] b, input logic perr);
		rxStart <= 1'b1;
		@(posedge ref_clk);
		rxStart <= 1'b0;
		waitEtu(10);
		rxValid <= 1'b1;
		rxByte <= b;
		rxParityErr <= perr;
		@(posedge ref_clk);
		rxValid <= 1'b0;
		rxByte <= ~b;
		rxParityErr <= ~perr;
		waitEtu(2);
	endtask
	task automatic sendBlock(input logic [7:0] b[$], input logic [7:0] flip, input int perrAt,
		input logic [1:0] epi);
		logic [7:0] lrc;
		logic [15:0] crc;
		lrc = flip;
		crc = crcOf(b) ^ {flip, 8'h00};
		waitEtu(24);
		foreach (b[i])
		begin
			sendChar(b[i], i == perrAt);
			lrc ^= b[i];
		end
		if (epi == 2'h1)
			sendChar(lrc, 1'b0);
		else if (epi == 2'h2)
		begin
			sendChar(crc[15:8], 1'b0);
			sendChar(crc[7:0], 1'b0);
		end
	endtask
endmodule

//--- dv/hdbf_framer_tb.sv
`timescale 1ns/100ps
module hdbf_framer_tb;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic etuTick, fdTick, rxStart, rxValid, rxParityErr, protoStart, txReq, txInfValid;
	logic txStrobe, charRepeat, txInfReady, txDone, txReject, rxHdrValid, rxInfValid;
	logic rxDone, strayChar, haveRight, bwtExpired, cfgReserved;
	logic [7:0] rxByte, txByte, txInfData, rxInfData, ifsc, ifsd, ra, rb;
	logic [7:0] strays = 8'h00;
	hdbf_pkg::hdbf_cfg_t cfg;
	hdbf_pkg::hdbf_hdr_t txHdr, rxHdr;
	hdbf_pkg::hdbf_err_t rxErr;
	int failures = 0, compares = 0, seed = 11584, cycles = 0, w;
	logic [7:0] expErr[$], expTx[$], expInf[$], expHdr[$];
	logic [23:0] bad[10] = '{24'hff0000, 24'h110000, 24'h0000ff, 24'h008101, 24'h00c201,
		24'h00e400, 24'h000100, 24'h00c100, 24'h008400, 24'h000021};
	always #12.5 ref_clk = ~ref_clk;
	hdbf_ifd_model hdbf_ifd_model_inst (.ref_clk, .etuTick, .fdTick, .rxStart, .rxValid,
		.rxByte, .rxParityErr);
	hdbf_framer hdbf_framer_inst (.ref_clk, .rst_n, .etuTick, .fdTick, .protoStart, .cfg,
		.rxStart, .rxValid, .rxByte, .rxParityErr, .txByte, .txStrobe, .charRepeat, .txReq,
		.txHdr, .txInfData, .txInfValid, .txInfReady, .txDone, .txReject, .rxHdr, .rxHdrValid,
		.rxInfData, .rxInfValid, .rxDone, .rxErr, .strayChar, .haveRight, .bwtExpired,
		.cfgReserved, .ifsc, .ifsd);
	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e || $isunknown(s))
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic finish_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic rxBlock(input logic [7:0] b[$], input logic [7:0] flip, input int perrAt,
		input logic [1:0] epi, input logic [7:0] e);
		expErr.push_back(e);
		for (w = 0; w < 3; w++)
			expHdr.push_back(b[w]);
		for (w = 3; w < b.size(); w++)
			expInf.push_back(b[w]);
		hdbf_ifd_model_inst.sendBlock(b, flip, perrAt, epi);
		for (w = 0; w < 4000 && haveRight !== 1'b1; w++)
			@(posedge ref_clk);
		check("haveRight", {7'h0, haveRight}, 8'h01);
		$display("rx block done");
	endtask
	task automatic txBlock(input logic [23:0] h, input logic [7:0] d);
		logic [7:0] l;
		logic [7:0] q[$];
		logic [15:0] c;
		q = '{h[23:16] & 8'h77, h[15:8], h[7:0]};
		if (h[7:0] == 8'h01)
			q.push_back(d);
		l = 8'h00;
		foreach (q[i])
		begin
			expTx.push_back(q[i]);
			l ^= q[i];
		end
		c = hdbf_ifd_model_inst.crcOf(q);
		if (cfg.tc[0])
		begin
			expTx.push_back(c[15:8]);
			expTx.push_back(c[7:0]);
		end
		else
			expTx.push_back(l);
		txReq <= 1'b1;
		txHdr <= h;
		txInfData <= d;
		txInfValid <= (h[7:0] == 8'h01);
		for (w = 0; w < 4000 && txDone !== 1'b1; w++)
		begin
			@(posedge ref_clk);
			if (haveRight !== 1'b1)
				txReq <= 1'b0;
			if (txInfReady === 1'b1)
			begin
				txInfValid <= 1'b0;
				txInfData <= ~d;
			end
		end
		check("haveRight", {7'h0, haveRight}, 8'h00);
		$display("tx block done");
	endtask
	always @(posedge ref_clk)
	begin
		cycles++;
		if (strayChar === 1'b1)
			strays <= strays + 8'h01;
		if (rxDone === 1'b1)
			check("rxErr", {5'h0, rxErr}, expErr.size() ? expErr.pop_front() : 8'hxx);
		if (rxHdrValid === 1'b1)
		begin
			check("rxHdr.nad", rxHdr.nad, expHdr.size() ? expHdr.pop_front() : 8'hxx);
			check("rxHdr.pcb", rxHdr.pcb, expHdr.size() ? expHdr.pop_front() : 8'hxx);
			check("rxHdr.len", rxHdr.len, expHdr.size() ? expHdr.pop_front() : 8'hxx);
		end
		if (rxInfValid === 1'b1)
			check("rxInfData", rxInfData, expInf.size() ? expInf.pop_front() : 8'hxx);
		if (txStrobe === 1'b1)
			check("txByte", txByte, expTx.size() ? expTx.pop_front() : 8'hxx);
		if (cycles == 80000)
		begin
			failures++;
			finish_test();
		end
	end
	initial
	begin
		protoStart = 1'b0;
		txReq = 1'b0;
		txHdr = 24'h000000;
		txInfData = 8'h00;
		txInfValid = 1'b0;
		cfg = {8'h40, 8'h41, 8'h00, 8'hff, 3'h7};
		ra = 8'($random(seed));
		rb = 8'($random(seed));
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		check("ifsd", ifsd, 8'h20);
		check("haveRight", {7'h0, haveRight}, 8'h00);
		protoStart <= 1'b1;
		@(posedge ref_clk);
		protoStart <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check("ifsc", ifsc, 8'h40);
		check("cfgReserved", {7'h0, cfgReserved}, 8'h00);
		// Address 00 opens the single unaddressed connection
		rxBlock('{8'h00, 8'h00, 8'h02, ra, rb}, 8'h00, -1, 1'b1, 8'h00);
		hdbf_ifd_model_inst.sendChar(8'h5a, 1'b0);
		check("strays", strays, 8'h01);
		foreach (bad[k])
		begin
			txReq <= 1'b1;
			txHdr <= bad[k];
			for (w = 0; w < 20 && txReject !== 1'b1; w++)
				@(posedge ref_clk);
			check("txReject", {7'h0, txReject}, 8'h01);
			txReq <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
		$display("reject table done");
		txBlock(24'h890001, ra ^ rb);
		rxBlock('{8'h00, 8'h40, 8'h00}, 8'h01, -1, 1'b1, 8'h02);
		txBlock(24'h00c101, 8'h30);
		check("ifsc", ifsc, 8'h30);
		rxBlock('{8'h00, 8'h00, 8'hff}, 8'h00, -1, 1'b0, 8'h04);
		txBlock(24'h008000, 8'h00);
		rxBlock('{8'h00, 8'hc1, 8'h01, 8'hfe}, 8'h00, -1, 1'b1, 8'h00);
		check("ifsd", ifsd, 8'hfe);
		txBlock(24'h009000, 8'h00);
		rxBlock('{8'h00, 8'h00, 8'h01, rb}, 8'h00, 3, 1'b1, 8'h01);
		txBlock(24'h008000, 8'h00);
		// Reply timer counts 11 etu plus 16 x 960 Fd/f units
		repeat (14000) @(posedge ref_clk iff fdTick);
		check("bwtExpired", {7'h0, bwtExpired}, 8'h00);
		for (w = 0; w < 4000 && bwtExpired !== 1'b1; w++)
			@(posedge ref_clk);
		check("bwtExpired", {7'h0, bwtExpired}, 8'h01);
		$display("reply timer done");
		// Restart in two-byte code mode with reserved code bits set
		cfg.tc <= 8'h03;
		protoStart <= 1'b1;
		@(posedge ref_clk);
		protoStart <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check("ifsd", ifsd, 8'h20);
		check("ifsc", ifsc, 8'h40);
		check("cfgReserved", {7'h0, cfgReserved}, 8'h01);
		rxBlock('{8'h00, 8'h00, 8'h01, ra}, 8'h00, -1, 2'h2, 8'h00);
		txBlock(24'h000001, rb);
		rxBlock('{8'h00, 8'h40, 8'h00}, 8'h01, -1, 2'h2, 8'h02);
		$display("crc mode done");
		finish_test();
	end
endmodule
bind hdbf_framer hdbf_framer_asserts hdbf_framer_asserts_inst (.ref_clk, .rst_n, .etuTick,
	.rxStart, .cfg, .txByte, .txStrobe, .charRepeat, .txInfReady, .txDone, .txReject, .rxDone,
	.rxErr, .haveRight, .ifsc, .ifsd);
